// [rtl/tkh_pkg.sv]
// Constants and types for the token-flag host controller
package tkh_pkg;
    localparam int unsigned TKH_DATA_W = 9;
    localparam int unsigned TKH_ADDR_W = 13;
    localparam int unsigned TKH_IDX_W = 3;
    localparam int unsigned TKH_NUM_FLAGS = 8;
    localparam int unsigned TKH_CLK_PERIOD_NS = 4;
    // Setup, strobe and gap widths in ns, converted to cycles rounding up
    localparam int unsigned TKH_SETUP_NS = 8;
    localparam int unsigned TKH_STROBE_NS = 20;
    localparam int unsigned TKH_GAP_NS = 8;
    localparam int unsigned TKH_SETUP_CYC = (TKH_SETUP_NS + TKH_CLK_PERIOD_NS - 1) / TKH_CLK_PERIOD_NS;
    localparam int unsigned TKH_STROBE_CYC = (TKH_STROBE_NS + TKH_CLK_PERIOD_NS - 1) / TKH_CLK_PERIOD_NS;
    localparam int unsigned TKH_GAP_CYC = (TKH_GAP_NS + TKH_CLK_PERIOD_NS - 1) / TKH_CLK_PERIOD_NS;
    localparam int unsigned TKH_CNT_W = 4;
    localparam logic [TKH_DATA_W-1:0] TKH_WR_ZERO = 9'h000;
    localparam logic [TKH_DATA_W-1:0] TKH_WR_ONE = 9'h001;
    localparam logic [TKH_ADDR_W-1:0] TKH_ADDR_RST = 13'h0000;
    localparam logic [TKH_IDX_W-1:0] TKH_IDX_RST = 3'h0;
    localparam logic [TKH_IDX_W-1:0] TKH_IDX_LAST = 3'h7;
    typedef enum logic [1:0] {
        TKH_CMD_CLAIM,
        TKH_CMD_RELEASE,
        TKH_CMD_POLL,
        TKH_CMD_INIT
    } tkh_cmd_t;
    typedef enum logic [1:0] {
        TKH_PH_SETUP,
        TKH_PH_STROBE,
        TKH_PH_GAP
    } tkh_phase_t;
endpackage : tkh_pkg

// [rtl/tkh_cycle.sv]
// One flag-space bus cycle: setup, strobe, gap
`timescale 1ns/1ps
`default_nettype none
module tkh_cycle (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic is_write,
    output logic busy,
    output logic done,
    output logic strobe,
    output logic sample
);
    import tkh_pkg::*;
    tkh_phase_t phase_ff, nxt_phase;
    logic active_ff, nxt_active;
    logic [TKH_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic write_ff, nxt_write;

    always_comb begin
        nxt_phase = phase_ff;
        nxt_active = active_ff;
        nxt_cnt = cnt_ff;
        nxt_write = write_ff;
        if (!active_ff) begin
            if (start) begin
                nxt_active = 1'b1;
                nxt_phase = TKH_PH_SETUP;
                nxt_cnt = TKH_CNT_W'(TKH_SETUP_CYC - 1);
                nxt_write = is_write;
            end
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end else begin
            unique case (phase_ff)
                TKH_PH_SETUP: begin
                    nxt_phase = TKH_PH_STROBE;
                    nxt_cnt = TKH_CNT_W'(TKH_STROBE_CYC - 1);
                end
                TKH_PH_STROBE: begin
                    // Strobe must fall between reads so the device relatches
                    nxt_phase = TKH_PH_GAP;
                    nxt_cnt = TKH_CNT_W'(TKH_GAP_CYC - 1);
                end
                TKH_PH_GAP: begin
                    // Back-to-back start keeps select low between write and read-back
                    if (start) begin
                        nxt_phase = TKH_PH_SETUP;
                        nxt_cnt = TKH_CNT_W'(TKH_SETUP_CYC - 1);
                        nxt_write = is_write;
                    end else begin
                        nxt_active = 1'b0;
                    end
                end
                default: begin
                    nxt_active = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_ff <= TKH_PH_SETUP;
            active_ff <= 1'b0;
            cnt_ff <= '0;
            write_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            active_ff <= nxt_active;
            cnt_ff <= nxt_cnt;
            write_ff <= nxt_write;
        end
    end

    assign busy = active_ff;
    assign strobe = active_ff && (phase_ff == TKH_PH_STROBE);
    assign done = active_ff && (phase_ff == TKH_PH_GAP) && (cnt_ff == '0);
    // Sample late in the strobe, when read data has settled
    assign sample = strobe && !write_ff && (cnt_ff == '0);
endmodule : tkh_cycle
`default_nettype wire

// [rtl/tkh_host.sv]
// Host controller driving one port of the dual-port token flags
`timescale 1ns/1ps
`default_nettype none
module tkh_host (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire tkh_pkg::tkh_cmd_t cmd_op,
    input wire logic [tkh_pkg::TKH_IDX_W-1:0] cmd_index,
    output logic rsp_valid,
    output logic rsp_granted,
    output logic rsp_fault,
    output logic [tkh_pkg::TKH_NUM_FLAGS-1:0] owned,
    output logic flag_space_select_n,
    output logic array_select_n,
    output logic rw_n,
    output logic out_enable_n,
    output logic [tkh_pkg::TKH_ADDR_W-1:0] addr,
    output logic [tkh_pkg::TKH_DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [tkh_pkg::TKH_DATA_W-1:0] data_in
);
    import tkh_pkg::*;
    typedef enum logic [2:0] {
        TKH_IDLE,
        TKH_WRITE,
        TKH_READ,
        TKH_INIT_WR,
        TKH_RESP
    } tkh_state_t;

    tkh_state_t state_ff, nxt_state;
    tkh_cmd_t op_ff, nxt_op;
    logic [TKH_IDX_W-1:0] idx_ff, nxt_idx;
    logic [TKH_DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [TKH_NUM_FLAGS-1:0] owned_ff, nxt_owned;
    logic granted_ff, nxt_granted;
    logic fault_ff, nxt_fault;
    logic [TKH_DATA_W-1:0] din_meta_ff, din_sync_ff;
    logic cyc_start, cyc_write, cyc_busy, cyc_done, cyc_strobe, cyc_sample;
    logic flag_low, flag_high;

    // Data pins are asynchronous to clk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            din_meta_ff <= '0;
            din_sync_ff <= '0;
        end else begin
            din_meta_ff <= data_in;
            din_sync_ff <= din_meta_ff;
        end
    end

    // Flag value arrives spread on all bits; mixed bits mean a bad read
    assign flag_low = (din_sync_ff == '0);
    assign flag_high = (din_sync_ff == '1);

    tkh_cycle u_cycle (
        .clk(clk),
        .rst_b(rst_b),
        .start(cyc_start),
        .is_write(cyc_write),
        .busy(cyc_busy),
        .done(cyc_done),
        .strobe(cyc_strobe),
        .sample(cyc_sample)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_idx = idx_ff;
        nxt_wdata = wdata_ff;
        nxt_owned = owned_ff;
        nxt_granted = granted_ff;
        nxt_fault = fault_ff;
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        unique case (state_ff)
            TKH_IDLE: begin
                if (cmd_valid) begin
                    nxt_op = cmd_op;
                    nxt_idx = cmd_index;
                    nxt_granted = 1'b0;
                    nxt_fault = 1'b0;
                    cyc_start = 1'b1;
                    unique case (cmd_op)
                        TKH_CMD_CLAIM: begin
                            nxt_wdata = TKH_WR_ZERO;
                            cyc_write = 1'b1;
                            nxt_state = TKH_WRITE;
                        end
                        TKH_CMD_RELEASE: begin
                            nxt_wdata = TKH_WR_ONE;
                            cyc_write = 1'b1;
                            nxt_state = TKH_WRITE;
                        end
                        TKH_CMD_POLL: begin
                            nxt_state = TKH_READ;
                        end
                        TKH_CMD_INIT: begin
                            nxt_idx = TKH_IDX_RST;
                            nxt_wdata = TKH_WR_ONE;
                            cyc_write = 1'b1;
                            nxt_state = TKH_INIT_WR;
                        end
                    endcase
                end
            end
            TKH_WRITE: begin
                if (cyc_done) begin
                    if (op_ff == TKH_CMD_CLAIM) begin
                        // Read back only after the zero is written
                        cyc_start = 1'b1;
                        nxt_state = TKH_READ;
                    end else begin
                        nxt_owned[idx_ff] = 1'b0;
                        nxt_granted = 1'b1;
                        nxt_state = TKH_RESP;
                    end
                end
            end
            TKH_READ: begin
                if (cyc_sample) begin
                    // Zero read back is ours; one means held opposite
                    nxt_granted = flag_low;
                    nxt_fault = !(flag_low || flag_high);
                    nxt_owned[idx_ff] = flag_low;
                end
                if (cyc_done) begin
                    nxt_state = TKH_RESP;
                end
            end
            TKH_INIT_WR: begin
                if (cyc_done) begin
                    nxt_owned[idx_ff] = 1'b0;
                    if (idx_ff == TKH_IDX_LAST) begin
                        nxt_granted = 1'b1;
                        nxt_state = TKH_RESP;
                    end else begin
                        nxt_idx = idx_ff + 1'b1;
                        cyc_start = 1'b1;
                        cyc_write = 1'b1;
                    end
                end
            end
            TKH_RESP: begin
                nxt_state = TKH_IDLE;
            end
            default: begin
                nxt_state = TKH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= TKH_IDLE;
            op_ff <= TKH_CMD_CLAIM;
            idx_ff <= TKH_IDX_RST;
            wdata_ff <= TKH_WR_ONE;
            owned_ff <= '0;
            granted_ff <= 1'b0;
            fault_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            idx_ff <= nxt_idx;
            wdata_ff <= nxt_wdata;
            owned_ff <= nxt_owned;
            granted_ff <= nxt_granted;
            fault_ff <= nxt_fault;
        end
    end

    // Pin drive is combinational from registered cycle state
    logic is_wr_state;
    assign is_wr_state = (state_ff == TKH_WRITE) || (state_ff == TKH_INIT_WR);
    assign flag_space_select_n = !cyc_busy;
    assign array_select_n = 1'b1;
    assign rw_n = !(cyc_strobe && is_wr_state);
    // Enable drops after each read, so repeated polls recapture
    assign out_enable_n = !(cyc_strobe && (state_ff == TKH_READ));
    // Upper address bits are don't-care to the device; held at zero
    assign addr = {{(TKH_ADDR_W-TKH_IDX_W){1'b0}}, idx_ff};
    assign data_out = wdata_ff;
    assign data_oe_n = !(cyc_busy && is_wr_state);
    assign cmd_ready = (state_ff == TKH_IDLE);
    assign rsp_valid = (state_ff == TKH_RESP);
    assign rsp_granted = granted_ff;
    assign rsp_fault = fault_ff;
    assign owned = owned_ff;
endmodule : tkh_host
`default_nettype wire

// [dv/tkh_host_monitor.sv]
// Pin protocol checker for the token-flag host
`timescale 1ns/1ps
`default_nettype none
module tkh_host_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rsp_valid,
    input wire logic flag_space_select_n,
    input wire logic array_select_n,
    input wire logic rw_n,
    input wire logic out_enable_n,
    input wire logic [tkh_pkg::TKH_ADDR_W-1:0] addr,
    input wire logic [tkh_pkg::TKH_DATA_W-1:0] data_out,
    input wire logic data_oe_n
);
    import tkh_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence wr_pulse;
        !rw_n [*5] ##1 rw_n;
    endsequence
    sequence rd_pulse;
        !out_enable_n [*5] ##1 out_enable_n;
    endsequence
    array_idle_a: assert property (array_select_n) else $error("array select active");
    wr_space_a: assert property (!rw_n |-> !flag_space_select_n && !data_oe_n)
        else $error("write outside flag space");
    rd_space_a: assert property (!out_enable_n |-> !flag_space_select_n && data_oe_n && rw_n)
        else $error("read outside flag space");
    addr_high_a: assert property (!flag_space_select_n |-> addr[TKH_ADDR_W-1:TKH_IDX_W] == '0)
        else $error("upper address bits set");
    wr_data_a: assert property (!rw_n |-> data_out[TKH_DATA_W-1:1] == '0)
        else $error("upper data bits set");
    wr_len_a: assert property ($fell(rw_n) |-> wr_pulse) else $error("write strobe length");
    rd_len_a: assert property ($fell(out_enable_n) |-> rd_pulse) else $error("read strobe length");
    rd_gap_a: assert property ($rose(out_enable_n) |-> out_enable_n [*2]) else $error("no gap");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("response not a pulse");
endmodule : tkh_host_monitor
bind tkh_host tkh_host_monitor u_mon (
    .clk(clk), .rst_b(rst_b), .rsp_valid(rsp_valid), .flag_space_select_n(flag_space_select_n),
    .array_select_n(array_select_n), .rw_n(rw_n), .out_enable_n(out_enable_n), .addr(addr),
    .data_out(data_out), .data_oe_n(data_oe_n)
);
`default_nettype wire

// [dv/tkh_flags_model.sv]
// Behavioural two-port token-flag device
`timescale 1ns/1ps
`default_nettype none
module tkh_flags_model (
    input wire logic l_sel_n,
    input wire logic l_rw_n,
    input wire logic l_oe_n,
    input wire logic [12:0] l_addr,
    input wire logic [8:0] l_d,
    output logic [8:0] l_q,
    input wire logic r_sel_n,
    input wire logic r_rw_n,
    input wire logic r_oe_n,
    input wire logic [2:0] r_idx,
    input wire logic r_d0,
    output logic [8:0] r_q
);
    logic [7:0] req_l = 'x;
    logic [7:0] req_r = 'x;
    logic [7:0] own_l = '0;
    logic [7:0] own_r = '0;
    logic cap_l = 1'b1;
    logic cap_r = 1'b1;
    wire logic rd_l = !l_sel_n && !l_oe_n;
    wire logic rd_r = !r_sel_n && !r_oe_n;
    // Left checked first, so a tie goes left
    function automatic void settle(input int i);
        if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
        if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
        if (!own_l[i] && !own_r[i]) begin
            if (req_l[i] === 1'b0) own_l[i] = 1'b1;
            else if (req_r[i] === 1'b0) own_r[i] = 1'b1;
        end
    endfunction : settle
    always @(posedge l_rw_n) if (!l_sel_n) begin
        req_l[l_addr[2:0]] = l_d[0];
        settle(l_addr[2:0]);
    end
    always @(posedge r_rw_n) if (!r_sel_n) begin
        req_r[r_idx] = r_d0;
        settle(r_idx);
    end
    always @(posedge rd_l) cap_l = !own_l[l_addr[2:0]];
    always @(posedge rd_r) cap_r = !own_r[r_idx];
    // Released bus shows the inverse so stale data cannot pass
    assign l_q = rd_l ? {9{cap_l}} : {9{!cap_l}};
    assign r_q = rd_r ? {9{cap_r}} : {9{!cap_r}};
endmodule : tkh_flags_model
`default_nettype wire

// [dv/tkh_host_tb.sv]
// Self-checking bench for the token-flag host
`timescale 1ns/1ps
`default_nettype none
module tkh_host_tb;
    import tkh_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    tkh_cmd_t cmd_op = TKH_CMD_INIT;
    logic [TKH_IDX_W-1:0] cmd_index = '0;
    logic cmd_ready, rsp_valid, rsp_granted, rsp_fault, sel_n, arr_n, rw_n, oe_n, doe_n;
    logic [TKH_NUM_FLAGS-1:0] owned;
    logic [TKH_ADDR_W-1:0] addr;
    logic [TKH_DATA_W-1:0] dout, l_q, r_q;
    wire logic [TKH_DATA_W-1:0] bus = !doe_n ? dout : l_q;
    logic r_sel_n = 1'b1, r_rw_n = 1'b1, r_oe_n = 1'b1, r_d0 = 1'b1;
    logic [2:0] r_idx = '0;
    int num_errors = 0, total_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    tkh_host DUT (.clk, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .cmd_index, .rsp_valid, .rsp_granted,
        .rsp_fault, .owned, .flag_space_select_n(sel_n), .array_select_n(arr_n), .rw_n,
        .out_enable_n(oe_n), .addr, .data_out(dout), .data_oe_n(doe_n), .data_in(bus));
    tkh_flags_model u_dev (.l_sel_n(sel_n), .l_rw_n(rw_n), .l_oe_n(oe_n), .l_addr(addr), .l_d(bus),
        .l_q, .r_sel_n, .r_rw_n, .r_oe_n, .r_idx, .r_d0, .r_q);
    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic cmd(input tkh_cmd_t op, input int i, input logic g);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_index <= i[2:0];
        @(negedge clk);
        chk("ready", cmd_ready, 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        chk("busy", cmd_ready, 1'b0);
        do @(negedge clk); while (rsp_valid !== 1'b1 && ++n < 200);
        chk("rsp", rsp_valid, 1'b1);
        chk("granted", rsp_granted, g);
        chk("fault", rsp_fault, 1'b0);
    endtask : cmd
    task automatic r_wr(input int i, input logic v);
        @(posedge clk);
        r_sel_n <= 1'b0;
        r_idx <= i[2:0];
        r_d0 <= v;
        @(posedge clk);
        r_rw_n <= 1'b0;
        repeat (2) @(posedge clk);
        r_rw_n <= 1'b1;
        @(posedge clk);
        r_sel_n <= 1'b1;
    endtask : r_wr
    task automatic r_rd(input int i, input logic v);
        @(posedge clk);
        r_sel_n <= 1'b0;
        r_oe_n <= 1'b0;
        r_idx <= i[2:0];
        repeat (2) @(negedge clk);
        chk("right flag", r_q, {9{v}});
        @(posedge clk);
        r_sel_n <= 1'b1;
        r_oe_n <= 1'b1;
    endtask : r_rd
    task automatic t_init();
        cmd(TKH_CMD_INIT, 0, 1'b1);
        for (int i = 0; i < 8; i++) r_wr(i, 1'b1);
        chk("owned", owned, 9'h000);
        $display("test init done");
    endtask : t_init
    task automatic t_each();
        for (int i = 0; i < 8; i++) begin
            cmd(TKH_CMD_CLAIM, i, 1'b1);
            r_rd(i, 1'b1);
        end
        chk("owned", owned, 9'h0FF);
        for (int i = 0; i < 8; i++) begin
            cmd(TKH_CMD_RELEASE, i, 1'b1);
            r_wr(i, 1'b0);
            r_rd(i, 1'b0);
            r_wr(i, 1'b1);
        end
        chk("owned", owned, 9'h000);
        $display("test each flag done");
    endtask : t_each
    task automatic t_pass();
        cmd(TKH_CMD_CLAIM, 7, 1'b1);
        r_wr(7, 1'b0);
        r_rd(7, 1'b1);
        cmd(TKH_CMD_POLL, 7, 1'b1);
        cmd(TKH_CMD_RELEASE, 7, 1'b1);
        r_rd(7, 1'b0);
        cmd(TKH_CMD_CLAIM, 7, 1'b0);
        cmd(TKH_CMD_RELEASE, 7, 1'b1);
        r_wr(7, 1'b1);
        cmd(TKH_CMD_POLL, 7, 1'b0);
        chk("owned", owned, 9'h000);
        $display("test handover done");
    endtask : t_pass
    task automatic t_race();
        fork
            cmd(TKH_CMD_CLAIM, 3, 1'b1);
            begin
                repeat (6) @(posedge clk);
                r_wr(3, 1'b0);
            end
        join
        r_rd(3, 1'b1);
        r_wr(3, 1'b1);
        cmd(TKH_CMD_RELEASE, 3, 1'b1);
        $display("test race done");
    endtask : t_race
    task automatic t_reset();
        cmd(TKH_CMD_CLAIM, 5, 1'b1);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk("owned", owned, 9'h000);
        chk("ready", cmd_ready, 1'b1);
        // Device still holds the token, so hand it back
        cmd(TKH_CMD_RELEASE, 5, 1'b1);
        r_rd(5, 1'b1);
        $display("test reset done");
    endtask : t_reset
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_init();
        t_each();
        t_pass();
        t_race();
        t_reset();
        tally_and_finish();
    end
    // Whole run needs under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            tally_and_finish();
        end
    end
endmodule : tkh_host_tb
`default_nettype wire
